//--- rsmr_host_model.sv
/*
 * Host model: master on the two-wire serial bus.
 * Assumes the bench resolves the data line with a pull-up.
 */
module rsmr_host_model (
    input  wire logic sys_clk_i,  // System clock
    input  wire logic sda_i,      // Resolved data line
    output logic      scl_o,      // Serial clock, still high between frames
    output logic      sda_o       // Data drive, one releases
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Four cycles per phase keeps the slave's setup margin
    task automatic hold();
        repeat (4) @(negedge sys_clk_i);
    endtask : hold
    // Also serves as repeated start, entered with the clock low
    task automatic start_c();
        sda_o = 1'b1;
        hold();
        scl_o = 1'b1;
        hold();
        sda_o = 1'b0;
        hold();
        scl_o = 1'b0;
        hold();
    endtask : start_c
    task automatic stop_c();
        sda_o = 1'b0;
        hold();
        scl_o = 1'b1;
        hold();
        sda_o = 1'b1;
        hold();
    endtask : stop_c
    // Nine bit cells, MSB first; the line is sampled late in each high phase
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            sda_o = d[i];
            hold();
            scl_o = 1'b1;
            hold();
            q[i]  = sda_i;
            scl_o = 1'b0;
            hold();
        end
    endtask : xfer
endmodule : rsmr_host_model

//--- rsmr_line_sampler.sv
/*
 * Samples the serial clock and data lines and derives edge, start and stop events.
 * Assumes both lines are already synchronous to sys_clk_i.
 */
module rsmr_line_sampler
    import rsmr_pkg::*;
(
    input  wire logic         sys_clk_i,  // System clock
    input  wire logic         reset_i,    // Synchronous reset, active high
    input  wire logic         scl_i,      // Serial clock line level
    input  wire logic         sda_i,      // Serial data line level
    output rsmr_bus_ev_t      ev_o        // Decoded line events
);

    logic scl_q;    // Current clock sample
    logic scl_d;    // Previous clock sample
    logic sda_q;    // Current data sample
    logic sda_d;    // Previous data sample

    // Two-deep history; idle bus reads high so reset to one
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            scl_q <= 1'b1;
            scl_d <= 1'b1;
            sda_q <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_q <= scl_i;
            scl_d <= scl_q;
            sda_q <= sda_i;
            sda_d <= sda_q;
        end
    end

    // Start and stop need the clock high on both samples, so they never meet an edge
    always_comb begin
        ev_o.scl_rise = scl_q & ~scl_d;
        ev_o.scl_fall = ~scl_q & scl_d;
        ev_o.start    = scl_q & scl_d & sda_d & ~sda_q;
        ev_o.stop     = scl_q & scl_d & ~sda_d & sda_q;
        ev_o.sda      = sda_q;
    end

endmodule : rsmr_line_sampler

//--- rsmr_mode_decode.sv
/*
 * Unpacks the four mode registers into per-regulator enable and low-power lines.
 * Assumes the bank is ordered mode a in bits 7:0 up to mode d in bits 31:24.
 */
module rsmr_mode_decode
    import rsmr_pkg::*;
#(
    parameter int N_LINREG = LINREG_COUNT  // Regulators decoded
)(
    input  wire logic [8*MODE_REGS-1:0] mode_bank_i,                // Mode registers
    output logic      [N_LINREG-1:0]    linreg_output_enable_o,     // Index 0 is regulator 1
    output logic      [N_LINREG-1:0]    linreg_low_power_select_o   // Index 0 is regulator 1
);

    // Regulator i sits in byte i/4, enable directly above its low-power bit
    for (genvar i = 0; i < N_LINREG; i++) begin : g_pair
        localparam int BASE = 8 * (i / PAIRS_PER_REG) + 2 * (i % PAIRS_PER_REG);
        assign linreg_output_enable_o[i]    = mode_bank_i[BASE + 1];
        assign linreg_low_power_select_o[i] = mode_bank_i[BASE];
    end

endmodule : rsmr_mode_decode

//--- rsmr_pkg.sv
/*
 * Shared constants and types for the regulator status and mode register slice.
 * Assumes an 8-bit register address space reached over a two-wire serial bus.
 */
package rsmr_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_PGOOD_MASK   = 8'h08;  // Power-good interrupt mask
    localparam logic [7:0] ADDR_STATUS_B     = 8'h0C;  // Buck and linreg 9..15 power-good
    localparam logic [7:0] ADDR_BOOST_STATUS = 8'h0D;  // Buck-boost status
    localparam logic [7:0] ADDR_RSVD_LO      = 8'h0E;  // Reserved gap, low
    localparam logic [7:0] ADDR_RSVD_HI      = 8'h0F;  // Reserved gap, high
    localparam logic [7:0] ADDR_MODE_A       = 8'h10;  // Linregs 1..4
    localparam logic [7:0] ADDR_MODE_B       = 8'h11;  // Linregs 5..8
    localparam logic [7:0] ADDR_MODE_C       = 8'h12;  // Linregs 9..12
    localparam logic [7:0] ADDR_MODE_D       = 8'h13;  // Linregs 13..15

    // Reset values
    localparam logic [7:0] RST_PGOOD_MASK = 8'hFF;  // All power-good events blocked
    localparam logic [7:0] RST_MODE       = 8'h00;  // All linregs off, normal mode
    localparam logic [7:0] RST_STATUS     = 8'h00;  // Status before first sample
    localparam logic [7:0] READ_ZERO      = 8'h00;  // Answer of unmapped addresses

    // Field layout
    localparam logic [7:0] MODE_D_WRITABLE = 8'h3F;  // Bits 7:6 reserved
    localparam int         BUCK_GOOD_BIT   = 7;      // In status b
    localparam int         BOOST_GOOD_BIT  = 2;      // In boost status
    localparam int         BOOST_OVP_BIT   = 1;      // In boost status
    localparam int         BOOST_OCP_BIT   = 0;      // In boost status
    localparam int         BOOST_RSVD_W    = 5;      // Bits 7:3 read zero
    localparam int         LINREG_COUNT    = 15;     // Linear regulators
    localparam int         PAIRS_PER_REG   = 4;      // Enable/low-power pairs per byte
    localparam int         MODE_REGS       = 4;      // Mode registers
    localparam int         STAT_B_LINREGS  = 7;      // Linregs 9..15 in status b

    // Serial framing
    localparam logic [3:0] BYTE_BITS = 4'h8;  // Bits per byte on the wire

    // Buck-boost status, packed in register bit order 2..0
    typedef struct packed {
        logic pgood;        // Power good
        logic overvoltage;  // Overvoltage protection active
        logic overcurrent;  // Overcurrent protection active
    } rsmr_boost_status_t;

    // Decoded serial line events
    typedef struct packed {
        logic scl_rise;  // Clock line went high
        logic scl_fall;  // Clock line went low
        logic start;     // Data fell while clock high
        logic stop;      // Data rose while clock high
        logic sda;       // Sampled data level
    } rsmr_bus_ev_t;

    // Serial slave states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WRITE,
        ST_WACK,
        ST_RDATA,
        ST_RACK
    } rsmr_state_t;

endpackage : rsmr_pkg

//--- rsmr_regs.sv
/*
 * Regulator status and mode register slice with its two-wire serial slave.
 * Assumes synchronous line inputs and an external pad that pulls data low
 * while sda_oe_o is high. Status inputs are level flags from the analog side.
 */
// Contract
// - 0x0C holds buck and linreg 15..9 good
// - 0x0D bit 2 is buck-boost good
// - 0x0D bit 1 is buck-boost overvoltage
// - 0x0D bit 0 overcurrent, 7:3 zero
// - Enable bit: zero off, one on
// - Low-power bit: zero normal, one low-power
// - 0x10 holds linregs 1..4, reset zero
// - 0x11 holds linregs 5..8, enable above
// - 0x12 holds linregs 9..12
// - 0x13 holds linregs 13..15, 7:6 reserved
// - 0x08 mask gates power-good events, one blocks
module rsmr_regs
    import rsmr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h60  // Serial slave address
)(
    input  wire logic                    sys_clk_i,                  // System clock, 200 MHz
    input  wire logic                    reset_i,                    // Synchronous reset, active high
    input  wire logic                    scl_i,                      // Serial clock line
    input  wire logic                    sda_i,                      // Serial data line level
    output logic                         sda_o,                      // Data drive value, always low
    output logic                         sda_oe_o,                   // High while pulling data low
    input  wire logic                    buck_power_good_flag_i,     // Buck power good
    input  wire logic [STAT_B_LINREGS-1:0] linreg_power_good_flag_i, // Bit 0 is linreg 9
    input  wire rsmr_boost_status_t      boost_status_i,             // Buck-boost flags
    output logic [LINREG_COUNT-1:0]      linreg_output_enable_o,     // Index 0 is linreg 1
    output logic [LINREG_COUNT-1:0]      linreg_low_power_select_o,  // Index 0 is linreg 1
    output logic [7:0]                   pgood_event_o               // Unmasked status b change
);

    rsmr_bus_ev_t       ev;          // Line events
    rsmr_state_t        state_q;     // Slave state
    logic [3:0]         bit_cnt_q;   // Bits seen in current byte
    logic [7:0]         shift_q;     // Receive shifter
    logic [7:0]         tx_q;        // Transmit shifter
    logic [7:0]         ptr_q;       // Register pointer
    logic               rw_q;        // Transfer is a read
    logic               first_q;     // Next written byte is the pointer
    logic               nack_q;      // Master refused more data
    logic               sda_oe_q;    // Data pull-down
    logic [7:0]         status_b_q;  // Buck and linreg good flags
    rsmr_boost_status_t boost_q;     // Buck-boost flags
    logic [7:0]         mask_q;      // Power-good event mask
    logic [7:0]         mode_q [MODE_REGS];  // Mode registers a..d
    logic [7:0]         next_status_b;       // Status about to be captured
    logic [7:0]         tx_load;             // Byte at the pointer
    logic               wr_stb;              // Data byte write, this cycle

    // Register read decode; unmapped addresses answer zero
    function automatic logic [7:0] rsmr_read(input logic [7:0] addr);
        logic [7:0] val;
        val = READ_ZERO;
        unique case (addr)
            ADDR_PGOOD_MASK:   val = mask_q;
            ADDR_STATUS_B:     val = status_b_q;
            ADDR_BOOST_STATUS: val = {{BOOST_RSVD_W{1'b0}}, boost_q};
            ADDR_MODE_A:       val = mode_q[0];
            ADDR_MODE_B:       val = mode_q[1];
            ADDR_MODE_C:       val = mode_q[2];
            ADDR_MODE_D:       val = mode_q[3];
            default:           val = READ_ZERO;
        endcase
        return val;
    endfunction : rsmr_read

    rsmr_line_sampler u_sampler (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .ev_o      (ev)
    );

    rsmr_mode_decode #(
        .N_LINREG (LINREG_COUNT)
    ) u_decode (
        .mode_bank_i               ({mode_q[3], mode_q[2], mode_q[1], mode_q[0]}),
        .linreg_output_enable_o    (linreg_output_enable_o),
        .linreg_low_power_select_o (linreg_low_power_select_o)
    );

    assign sda_o    = 1'b0;      // Open drain: only ever pulls low
    assign sda_oe_o = sda_oe_q;
    assign tx_load  = rsmr_read(ptr_q);
    assign wr_stb   = (state_q == ST_WRITE) && ev.scl_fall && (bit_cnt_q == BYTE_BITS) && !first_q;
    assign next_status_b = {buck_power_good_flag_i, linreg_power_good_flag_i};

    // Serial slave: address, pointer, data bytes with auto-increment
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            tx_q      <= 8'h00;
            ptr_q     <= 8'h00;
            rw_q      <= 1'b0;
            first_q   <= 1'b0;
            nack_q    <= 1'b0;
            sda_oe_q  <= 1'b0;
        end else if (ev.start) begin
            // Repeated start aborts any byte in flight
            state_q   <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            sda_oe_q  <= 1'b0;
        end else if (ev.stop) begin
            state_q   <= ST_IDLE;
            sda_oe_q  <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    // Wait for a start
                end
                ST_ADDR: begin
                    if (ev.scl_rise) begin
                        shift_q   <= {shift_q[6:0], ev.sda};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (ev.scl_fall && bit_cnt_q == BYTE_BITS) begin
                        if (shift_q[7:1] == DEV_ADDR) begin
                            sda_oe_q <= 1'b1;   // Acknowledge our address
                            rw_q     <= shift_q[0];
                            state_q  <= ST_ADDR_ACK;
                        end else begin
                            state_q  <= ST_IDLE;  // Someone else's transfer
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (ev.scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        first_q   <= 1'b1;
                        if (rw_q) begin
                            tx_q     <= tx_load;
                            sda_oe_q <= ~tx_load[7];
                            state_q  <= ST_RDATA;
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q  <= ST_WRITE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (ev.scl_rise) begin
                        shift_q   <= {shift_q[6:0], ev.sda};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (ev.scl_fall && bit_cnt_q == BYTE_BITS) begin
                        sda_oe_q <= 1'b1;
                        state_q  <= ST_WACK;
                        if (first_q) begin
                            ptr_q   <= shift_q;
                            first_q <= 1'b0;
                        end else begin
                            ptr_q   <= ptr_q + 8'h01;
                        end
                    end
                end
                ST_WACK: begin
                    if (ev.scl_fall) begin
                        sda_oe_q  <= 1'b0;
                        bit_cnt_q <= 4'h0;
                        state_q   <= ST_WRITE;
                    end
                end
                ST_RDATA: begin
                    if (ev.scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (ev.scl_fall) begin
                        if (bit_cnt_q == BYTE_BITS) begin
                            sda_oe_q <= 1'b0;   // Release for the master's answer
                            ptr_q    <= ptr_q + 8'h01;
                            state_q  <= ST_RACK;
                        end else begin
                            sda_oe_q <= ~tx_q[6];
                            tx_q     <= {tx_q[6:0], 1'b0};
                        end
                    end
                end
                ST_RACK: begin
                    if (ev.scl_rise) begin
                        nack_q <= ev.sda;
                    end else if (ev.scl_fall) begin
                        if (!nack_q) begin
                            tx_q      <= tx_load;
                            sda_oe_q  <= ~tx_load[7];
                            bit_cnt_q <= 4'h0;
                            state_q   <= ST_RDATA;
                        end else begin
                            state_q   <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Status capture; flags are levels, so a read shows the last sampled state
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            status_b_q <= RST_STATUS;
            boost_q    <= rsmr_boost_status_t'(RST_STATUS[2:0]);
        end else begin
            status_b_q <= next_status_b;
            boost_q    <= boost_status_i;
        end
    end

    // Power-good change events, gated by the mask; a one blocks
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pgood_event_o <= 8'h00;
        end else begin
            pgood_event_o <= (next_status_b ^ status_b_q) & ~mask_q;
        end
    end

    // Writable registers; status and reserved addresses ignore writes
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            mask_q <= RST_PGOOD_MASK;
            for (int k = 0; k < MODE_REGS; k++) begin
                mode_q[k] <= RST_MODE;
            end
        end else if (wr_stb) begin
            unique case (ptr_q)
                ADDR_PGOOD_MASK: mask_q    <= shift_q;
                ADDR_MODE_A:     mode_q[0] <= shift_q;
                ADDR_MODE_B:     mode_q[1] <= shift_q;
                ADDR_MODE_C:     mode_q[2] <= shift_q;
                ADDR_MODE_D:     mode_q[3] <= shift_q & MODE_D_WRITABLE;
                default: begin
                    // Read-only or reserved: no effect
                end
            endcase
        end
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence addr_hit_s;
        state_q == ST_ADDR && ev.scl_fall && bit_cnt_q == BYTE_BITS && shift_q[7:1] == DEV_ADDR;
    endsequence
    sequence mode_write_s(logic [7:0] addr);
        wr_stb && ptr_q == addr;
    endsequence
    sequence rsvd_write_s;
        wr_stb && (ptr_q == ADDR_RSVD_LO || ptr_q == ADDR_RSVD_HI);
    endsequence

    addr_ack_a: assert property (addr_hit_s |=> sda_oe_o && state_q == ST_ADDR_ACK)
        else $error("address match not acknowledged");
    stat_b_capture_a: assert property (1 |=> status_b_q == {$past(buck_power_good_flag_i),
                                                          $past(linreg_power_good_flag_i)})
        else $error("status b does not follow flags");
    boost_good_a: assert property ($rose(boost_status_i.pgood) |=> boost_q.pgood)
        else $error("boost good flag not captured");
    boost_ovp_a: assert property (ptr_q == ADDR_BOOST_STATUS |->
                                  tx_load[BOOST_OVP_BIT] == boost_q.overvoltage)
        else $error("overvoltage bit misplaced");
    boost_rsvd_a: assert property (ptr_q == ADDR_BOOST_STATUS |->
                                   tx_load == {5'b0_0000, boost_q})
        else $error("boost status layout wrong");
    mode_a_pair_a: assert property (mode_write_s(ADDR_MODE_A) |=>
                                    linreg_output_enable_o[0] == $past(shift_q[1]) &&
                                    linreg_low_power_select_o[3] == $past(shift_q[6]))
        else $error("mode a pair placement wrong");
    mode_b_pair_a: assert property (mode_write_s(ADDR_MODE_B) |=>
                                    linreg_output_enable_o[4] == $past(shift_q[1]) &&
                                    linreg_low_power_select_o[4] == $past(shift_q[0]))
        else $error("mode b pair placement wrong");
    mode_c_pair_a: assert property (mode_write_s(ADDR_MODE_C) |=>
                                    linreg_output_enable_o[11] == $past(shift_q[7]) &&
                                    linreg_low_power_select_o[8] == $past(shift_q[0]))
        else $error("mode c pair placement wrong");
    mode_d_rsvd_a: assert property (mode_write_s(ADDR_MODE_D) |=>
                                    mode_q[3][7:6] == 2'b00 && mode_q[3][5:0] == $past(shift_q[5:0]))
        else $error("mode d reserved bits written");
    enable_level_a: assert property ($rose(mode_q[0][1]) |-> linreg_output_enable_o[0])
        else $error("enable bit does not switch output on");
    low_power_level_a: assert property ($rose(mode_q[1][6]) |-> linreg_low_power_select_o[7])
        else $error("low-power bit does not select low power");
    mask_gate_a: assert property ((pgood_event_o & $past(mask_q)) == 8'h00)
        else $error("masked power-good event leaked");
    rsvd_write_a: assert property (rsvd_write_s |=> $stable(mask_q) && $stable(mode_q[0]) &&
                                   $stable(mode_q[3]))
        else $error("reserved write changed state");
    rsvd_read_a: assert property ((ptr_q == ADDR_RSVD_LO || ptr_q == ADDR_RSVD_HI) |->
                                  tx_load == 8'h00)
        else $error("reserved address reads non-zero");

    // End of an outgoing byte; the master owns the ninth bit
    sequence rdata_end_s;
        state_q == ST_RDATA && ev.scl_fall && bit_cnt_q == BYTE_BITS;
    endsequence
    // Holding data low here would turn the master's NACK into an ACK
    read_release_a: assert property (rdata_end_s |=> !sda_oe_o && state_q == ST_RACK)
        else $error("data not released for master acknowledge");
    // Every received byte is answered, even to read-only places
    write_ack_a: assert property (state_q == ST_WRITE && ev.scl_fall && bit_cnt_q == BYTE_BITS |=> sda_oe_o)
        else $error("written byte not acknowledged");

endmodule : rsmr_regs

//--- testbench.sv
/*
 * Self-checking bench for the register slice, driven through the host model.
 * Assumes the pad pulls data low while the slave enables its driver.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rsmr_pkg::*;
    localparam logic [6:0] SLV = 7'h60;  // Slave address
    logic               sys_clk_i = 1'b0;  // Clock
    logic               reset_i   = 1'b1;  // Reset
    logic               scl, host_sda, sda_oe, dev_sda, buck = 1'b0;  // Bus and buck flag
    logic [6:0]         lpg = 7'h00;   // Linreg 9..15 flags
    rsmr_boost_status_t bst = 3'h0;    // Buck-boost flags
    logic [14:0]        en, lp;        // Mode outputs
    logic [7:0]         ev, v;         // Events, read data
    int                 errors = 0, comparisons = 0, cycles = 0;
    // Open drain with pull-up: low if either side pulls
    wire sda = host_sda & (~sda_oe | dev_sda);
    always #2.5 sys_clk_i = ~sys_clk_i;
    rsmr_regs u_rsmr_regs (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda), .sda_o(dev_sda),
        .sda_oe_o(sda_oe), .buck_power_good_flag_i(buck), .linreg_power_good_flag_i(lpg), .boost_status_i(bst),
        .linreg_output_enable_o(en), .linreg_low_power_select_o(lp), .pgood_event_o(ev));
    rsmr_host_model u_rsmr_host_model (.sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_o(host_sda));
    // Hang guard, well above the run's length
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [29:0] got, input logic [29:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Pointer byte then n data bytes, lowest byte first
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n);
        logic [8:0] q;
        u_rsmr_host_model.start_c();
        u_rsmr_host_model.xfer({SLV, 2'b01}, q);
        u_rsmr_host_model.xfer({a, 1'b1}, q);
        for (int i = 0; i < n; i++) u_rsmr_host_model.xfer({d[8*i+:8], 1'b1}, q);
        u_rsmr_host_model.stop_c();
    endtask : wr
    // Pointer write, repeated start, one byte ended by master NACK
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        logic [8:0] q;
        u_rsmr_host_model.start_c();
        u_rsmr_host_model.xfer({SLV, 2'b01}, q);
        u_rsmr_host_model.xfer({a, 1'b1}, q);
        u_rsmr_host_model.start_c();
        u_rsmr_host_model.xfer({SLV, 2'b11}, q);
        u_rsmr_host_model.xfer(9'h1FF, q);
        u_rsmr_host_model.stop_c();
        r = q[8:1];
    endtask : rd
    // Two-byte burst read: master ACK after the first byte, NACK after the second
    task automatic rd2(input logic [7:0] a, output logic [15:0] r);
        logic [8:0] q0, q1;
        u_rsmr_host_model.start_c();
        u_rsmr_host_model.xfer({SLV, 2'b01}, q0);
        u_rsmr_host_model.xfer({a, 1'b1}, q0);
        u_rsmr_host_model.start_c();
        u_rsmr_host_model.xfer({SLV, 2'b11}, q0);
        u_rsmr_host_model.xfer(9'h1FE, q0);
        u_rsmr_host_model.xfer(9'h1FF, q1);
        u_rsmr_host_model.stop_c();
        r = {q0[8:1], q1[8:1]};
    endtask : rd2
    // Reset values of mask and the four mode registers
    task automatic t_reset();
        for (int i = 0; i < 5; i++) begin
            rd((i == 0) ? 8'h08 : 8'h0F + 8'(i), v);
            chk(30'(v), (i == 0) ? 30'h0000_00FF : 30'h0000_0000);
        end
    endtask : t_reset
    // Burst write of all four mode registers, outputs and top byte readback
    task automatic t_modes();
        logic [31:0] bank;
        logic [29:0] exp;
        logic [15:0] w;
        bank = 32'h3FC3_5AA5;
        wr(8'h10, 32'hFFC3_5AA5, 4);
        for (int k = 0; k < 15; k++) exp[k] = bank[2*k+1];
        for (int k = 0; k < 15; k++) exp[15+k] = bank[2*k];
        chk({lp, en}, exp);
        rd(8'h13, v);
        chk(30'(v), 30'h0000_003F);
        rd2(8'h12, w);
        chk(30'(w), 30'h0000_C33F);
    endtask : t_modes
    // Two complementary flag patterns through both status registers
    task automatic t_status();
        for (int i = 0; i < 2; i++) begin
            buck = (i == 0);
            lpg  = (i == 0) ? 7'h41 : 7'h3E;
            bst  = (i == 0) ? 3'h5 : 3'h2;
            rd(8'h0C, v);
            chk(30'(v), 30'({buck, lpg}));
            rd(8'h0D, v);
            chk(30'(v), 30'({5'h00, bst}));
        end
    endtask : t_status
    // Writes into the gap and a read-only place leave nothing behind
    task automatic t_rsvd();
        wr(8'h0E, 32'h0000_FFFF, 2);
        wr(8'h0C, 32'h0000_00FF, 1);
        rd(8'h0E, v);
        chk(30'(v), 30'h0000_0000);
        rd(8'h0F, v);
        chk(30'(v), 30'h0000_0000);
        rd(8'h0C, v);
        chk(30'(v), 30'({buck, lpg}));
    endtask : t_rsvd
    // Only the unmasked buck flag may raise an event
    task automatic t_event();
        logic [7:0] acc;
        acc = 8'h00;
        wr(8'h08, 32'h0000_007F, 1);
        rd(8'h08, v);
        chk(30'(v), 30'h0000_007F);
        buck   = ~buck;
        lpg[0] = ~lpg[0];
        repeat (8) begin
            @(negedge sys_clk_i);
            acc |= ev;
        end
        chk(30'(acc), 30'h0000_0080);
    endtask : t_event
    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (10) @(negedge sys_clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        t_reset();
        t_modes();
        t_status();
        t_rsvd();
        t_event();
        print_verdict();
    end
endmodule : testbench
